// >>> common/e1rb_defs.svh
`ifndef E1RB_DEFS_SVH
`define E1RB_DEFS_SVH

`define E1RB_CHANNELS       8
`define E1RB_ADDR_W         5
`define E1RB_DATA_W         8

`define E1RB_OFF_RAIL       5'h00
`define E1RB_OFF_CODE       5'h01
`define E1RB_OFF_CRS        5'h02
`define E1RB_OFF_RXPD       5'h03
`define E1RB_OFF_TXPD       5'h04
`define E1RB_OFF_EXZ        5'h05
`define E1RB_OFF_VIOL       5'h06
`define E1RB_OFF_EQ         5'h07
`define E1RB_OFF_SWRST      5'h0a
`define E1RB_OFF_BANK       5'h1f

`define E1RB_BANK_PRIMARY   8'h00
`define E1RB_BANK_EXPANDED  8'haa
`define E1RB_EXP_RESET      8'h00
`define E1RB_SWRST_RDVAL    8'hff

`define E1RB_CLK_MHZ        125
`define E1RB_SWRST_NS       1000
`define E1RB_SWRST_CYCLES   ((`E1RB_SWRST_NS * `E1RB_CLK_MHZ + 999) / 1000)
`define E1RB_TCLK_LOW_NS    4000
`define E1RB_TCLK_LOW_CYCLES ((`E1RB_TCLK_LOW_NS * `E1RB_CLK_MHZ + 999) / 1000)
`define E1RB_CNT_W          10

`define E1RB_PIN_W          32
`define E1RB_PIN_CS         31
`define E1RB_PIN_WR         30
`define E1RB_PIN_RD         29
`define E1RB_PIN_ADDR_LSB   24
`define E1RB_PIN_DATA_LSB   16
`define E1RB_PIN_TDN_LSB    8
`define E1RB_PIN_TCLK_LSB   0
`define E1RB_PIN_RST        32'he000_0000

`endif

// >>> common/e1rb_pkg.sv
package e1rb_pkg;
  typedef enum logic [1:0] {
    E1RB_ST_RUN   = 2'b01,
    E1RB_ST_SWRST = 2'b10
  } e1rb_state_e;

  typedef logic [7:0] e1rb_byte_t;
endpackage : e1rb_pkg

// >>> common/e1rb_chan_if.sv
`timescale 1ns/1ps
interface e1rb_chan_if;
  logic tclk_level;
  logic clock_low;
  modport watch (input tclk_level, output clock_low);
  modport ctrl  (output tclk_level, input clock_low);
endinterface : e1rb_chan_if

// >>> logic/e1rb_tclk_watch.sv
`timescale 1ns/1ps
`include "e1rb_defs.svh"
module e1rb_tclk_watch import e1rb_pkg::*; #(
  parameter int unsigned LOW_LIMIT = `E1RB_TCLK_LOW_CYCLES
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  // channel link to the controller
  e1rb_chan_if.watch        ch
);
  localparam logic [`E1RB_CNT_W-1:0] LIMIT_M1 = LOW_LIMIT[`E1RB_CNT_W-1:0] - 1'b1;

  logic [`E1RB_CNT_W-1:0] low_cnt_q;
  logic                   low_q;

  // a stopped transmit clock counts as a powered down transmitter
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_cnt_q <= '0;
      low_q     <= 1'b0;
    end else if (ch.tclk_level) begin
      low_cnt_q <= '0;
      low_q     <= 1'b0;
    end else if (low_cnt_q == LIMIT_M1) begin
      low_q     <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  assign ch.clock_low = low_q;
endmodule : e1rb_tclk_watch

// >>> logic/e1rb_bank_ctrl.sv
//
// Contract
// - writing 00h to pointer selects primary bank
// - writing aah to pointer selects expanded bank
// - power-up leaves pointer at primary bank
// - rail override forces single rail, needs recovery
// - forced single rail: 0 hdb3, 1 ami
// - recovery bit: 0 enabled, 1 disabled
// - receiver power-down bit powers receiver down
// - transmitter power-down bit gives high-z driver
// - low transmit clock also powers transmitter down
// - excess-zero bit enables hdb3 single-rail detection
// - violation bit 0 keeps hdb3 detection active
// - equalizer bit enables receive equalizer
// - reset register write starts 1 us reset
`timescale 1ns/1ps
`include "e1rb_defs.svh"
module e1rb_bank_ctrl import e1rb_pkg::*; (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  // host parallel port
  input  wire logic                    host_cs_n_in,
  input  wire logic                    host_wr_n_in,
  input  wire logic                    host_rd_n_in,
  input  wire logic [`E1RB_ADDR_W-1:0] host_addr_in,
  input  wire logic [`E1RB_DATA_W-1:0] host_data_in,
  output logic      [`E1RB_DATA_W-1:0] host_data_out,
  output logic                         host_data_oe_out,
  // line pins
  input  wire logic [7:0]              transmit_negative_data_pin_in,
  input  wire logic [7:0]              transmit_clock_pin_in,
  // bank and reset state
  output logic                         bank_expanded_out,
  output logic                         sw_reset_active_out,
  // per-channel controls to the datapath
  output logic      [7:0]              single_rail_out,
  output logic      [7:0]              ami_select_out,
  output logic      [7:0]              clock_recovery_off_out,
  output logic      [7:0]              rx_powerdown_out,
  output logic      [7:0]              tx_powerdown_out,
  output logic      [7:0]              tx_driver_hiz_out,
  output logic      [7:0]              excess_zero_detect_out,
  output logic      [7:0]              violation_detect_out,
  output logic      [7:0]              rx_equalizer_out
);
  localparam logic [`E1RB_CNT_W-1:0] SWRST_LAST = `E1RB_CNT_W'(`E1RB_SWRST_CYCLES - 1);

  // pin synchronisers
  logic [`E1RB_PIN_W-1:0] pin_raw;
  logic [`E1RB_PIN_W-1:0] sync1_q;
  logic [`E1RB_PIN_W-1:0] sync2_q;
  logic [`E1RB_PIN_W-1:0] sync3_q;
  logic [`E1RB_PIN_W-1:0] pin_f_q;

  // host decode
  logic                    cs_f;
  logic                    wr_f;
  logic                    rd_f;
  logic [`E1RB_ADDR_W-1:0] addr_f;
  e1rb_byte_t              data_f;
  logic [7:0]              tdn_f;
  logic [7:0]              tclk_f;
  logic                    wr_prev_q;
  logic                    wr_event;
  logic                    expanded;
  logic                    exp_hit;
  logic                    bank_hit;
  logic                    swrst_hit;
  e1rb_byte_t              rd_mux;

  // registers
  e1rb_byte_t  bank_pointer_q;
  e1rb_byte_t  rail_mode_override_q;
  e1rb_byte_t  line_code_select_q;
  e1rb_byte_t  clock_recovery_disable_q;
  e1rb_byte_t  receiver_powerdown_q;
  e1rb_byte_t  transmitter_powerdown_q;
  e1rb_byte_t  excess_zero_detect_enable_q;
  e1rb_byte_t  violation_detect_disable_q;
  e1rb_byte_t  receive_equalizer_enable_q;

  // software reset sequencer
  e1rb_state_e            state_q;
  logic [`E1RB_CNT_W-1:0] swrst_cnt_q;
  logic                   in_reset;

  // per-channel derived modes
  logic [7:0] forced_single;
  logic [7:0] single_rail;
  logic [7:0] ami_sel;
  logic [7:0] hdb3_single;
  wire  logic [7:0] tclk_low;

  assign pin_raw = {host_cs_n_in, host_wr_n_in, host_rd_n_in, host_addr_in, host_data_in,
                    transmit_negative_data_pin_in, transmit_clock_pin_in};

  // first stage is read only by the second stage
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= `E1RB_PIN_RST;
      sync2_q <= `E1RB_PIN_RST;
      sync3_q <= `E1RB_PIN_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a bit only moves once two late stages agree, so a pin caught mid-edge cannot glitch decode
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_f_q <= `E1RB_PIN_RST;
    end else begin
      for (int i = 0; i < `E1RB_PIN_W; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_f_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign cs_f   = pin_f_q[`E1RB_PIN_CS];
  assign wr_f   = pin_f_q[`E1RB_PIN_WR];
  assign rd_f   = pin_f_q[`E1RB_PIN_RD];
  assign addr_f = pin_f_q[`E1RB_PIN_ADDR_LSB +: `E1RB_ADDR_W];
  assign data_f = pin_f_q[`E1RB_PIN_DATA_LSB +: `E1RB_DATA_W];
  assign tdn_f  = pin_f_q[`E1RB_PIN_TDN_LSB +: 8];
  assign tclk_f = pin_f_q[`E1RB_PIN_TCLK_LSB +: 8];

  // the write is taken at the rising end of the strobe, when address and data have settled
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_f;
    end
  end

  // writes during the soft reset are dropped so the defaults hold for the whole reset cycle
  assign wr_event  = wr_f && !wr_prev_q && !cs_f && !in_reset;
  assign expanded  = (bank_pointer_q == `E1RB_BANK_EXPANDED);
  assign bank_hit  = (addr_f == `E1RB_OFF_BANK);
  assign exp_hit   = expanded && (addr_f <= `E1RB_OFF_EQ);
  assign swrst_hit = !expanded && (addr_f == `E1RB_OFF_SWRST);
  assign in_reset  = (state_q == E1RB_ST_SWRST);

  // reset sequencer; any write to the reset register outside a reset starts it, its content stays fixed
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q     <= E1RB_ST_RUN;
      swrst_cnt_q <= '0;
    end else begin
      case (state_q)
        E1RB_ST_RUN: begin
          swrst_cnt_q <= '0;
          if (wr_event && swrst_hit) begin
            state_q <= E1RB_ST_SWRST;
          end
        end
        E1RB_ST_SWRST: begin
          if (swrst_cnt_q == SWRST_LAST) begin
            state_q     <= E1RB_ST_RUN;
            swrst_cnt_q <= '0;
          end else begin
            swrst_cnt_q <= swrst_cnt_q + 1'b1;
          end
        end
        default: begin
          state_q     <= E1RB_ST_RUN;
          swrst_cnt_q <= '0;
        end
      endcase
    end
  end

  // pointer holds any written value; only aah opens the expanded bank
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_pointer_q <= `E1RB_BANK_PRIMARY;
    end else if (in_reset) begin
      bank_pointer_q <= `E1RB_BANK_PRIMARY;
    end else if (wr_event && bank_hit) begin
      bank_pointer_q <= data_f;
    end
  end

  // expanded registers, bit n belongs to channel n
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rail_mode_override_q        <= `E1RB_EXP_RESET;
      line_code_select_q          <= `E1RB_EXP_RESET;
      clock_recovery_disable_q    <= `E1RB_EXP_RESET;
      receiver_powerdown_q        <= `E1RB_EXP_RESET;
      transmitter_powerdown_q     <= `E1RB_EXP_RESET;
      excess_zero_detect_enable_q <= `E1RB_EXP_RESET;
      violation_detect_disable_q  <= `E1RB_EXP_RESET;
      receive_equalizer_enable_q  <= `E1RB_EXP_RESET;
    end else if (in_reset) begin
      rail_mode_override_q        <= `E1RB_EXP_RESET;
      line_code_select_q          <= `E1RB_EXP_RESET;
      clock_recovery_disable_q    <= `E1RB_EXP_RESET;
      receiver_powerdown_q        <= `E1RB_EXP_RESET;
      transmitter_powerdown_q     <= `E1RB_EXP_RESET;
      excess_zero_detect_enable_q <= `E1RB_EXP_RESET;
      violation_detect_disable_q  <= `E1RB_EXP_RESET;
      receive_equalizer_enable_q  <= `E1RB_EXP_RESET;
    end else if (wr_event && exp_hit) begin
      case (addr_f)
        `E1RB_OFF_RAIL: rail_mode_override_q        <= data_f;
        `E1RB_OFF_CODE: line_code_select_q          <= data_f;
        `E1RB_OFF_CRS:  clock_recovery_disable_q    <= data_f;
        `E1RB_OFF_RXPD: receiver_powerdown_q        <= data_f;
        `E1RB_OFF_TXPD: transmitter_powerdown_q     <= data_f;
        `E1RB_OFF_EXZ:  excess_zero_detect_enable_q <= data_f;
        `E1RB_OFF_VIOL: violation_detect_disable_q  <= data_f;
        `E1RB_OFF_EQ:   receive_equalizer_enable_q  <= data_f;
        default: begin
        end
      endcase
    end
  end

  // read mux; primary-bank registers other than the pointer and reset live elsewhere and read zero here
  always_comb begin
    rd_mux = 8'h00;
    if (bank_hit) begin
      rd_mux = bank_pointer_q;
    end else if (swrst_hit) begin
      rd_mux = `E1RB_SWRST_RDVAL;
    end else if (exp_hit) begin
      case (addr_f)
        `E1RB_OFF_RAIL: rd_mux = rail_mode_override_q;
        `E1RB_OFF_CODE: rd_mux = line_code_select_q;
        `E1RB_OFF_CRS:  rd_mux = clock_recovery_disable_q;
        `E1RB_OFF_RXPD: rd_mux = receiver_powerdown_q;
        `E1RB_OFF_TXPD: rd_mux = transmitter_powerdown_q;
        `E1RB_OFF_EXZ:  rd_mux = excess_zero_detect_enable_q;
        `E1RB_OFF_VIOL: rd_mux = violation_detect_disable_q;
        `E1RB_OFF_EQ:   rd_mux = receive_equalizer_enable_q;
        default:        rd_mux = 8'h00;
      endcase
    end
  end

  // data bus is driven only while chip select and read strobe are both low
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_data_out    <= 8'h00;
      host_data_oe_out <= 1'b0;
    end else begin
      host_data_out    <= rd_mux;
      host_data_oe_out <= !cs_f && !rd_f;
    end
  end

  // transmit clock watchers, one per channel
  for (genvar g = 0; g < `E1RB_CHANNELS; g++) begin : g_chan
    e1rb_chan_if chan_if ();
    assign chan_if.tclk_level = tclk_f[g];
    assign tclk_low[g]        = chan_if.clock_low;
    e1rb_tclk_watch #(
      .LOW_LIMIT (`E1RB_TCLK_LOW_CYCLES)
    ) u_watch (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .ch      (chan_if.watch)
    );
  end

  // override is honoured only while clock recovery runs
  assign forced_single = rail_mode_override_q & ~clock_recovery_disable_q;
  assign single_rail   = forced_single | tdn_f;
  assign ami_sel       = forced_single & line_code_select_q;
  assign hdb3_single   = single_rail & ~ami_sel;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      single_rail_out <= 8'h00;
      ami_select_out  <= 8'h00;
    end else begin
      single_rail_out <= single_rail;
      ami_select_out  <= ami_sel;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clock_recovery_off_out <= 8'h00;
      rx_powerdown_out       <= 8'h00;
      rx_equalizer_out       <= 8'h00;
    end else begin
      clock_recovery_off_out <= clock_recovery_disable_q;
      rx_powerdown_out       <= receiver_powerdown_q;
      rx_equalizer_out       <= receive_equalizer_enable_q;
    end
  end

  // a stopped transmit clock powers the transmitter down just as the register bit does
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_powerdown_out <= 8'h00;
    end else begin
      tx_powerdown_out <= transmitter_powerdown_q | tclk_low;
    end
  end

  // the driver goes high-z whenever the transmitter is down; own flop so the pad enable can sit at the pad
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_driver_hiz_out <= 8'h00;
    end else begin
      tx_driver_hiz_out <= transmitter_powerdown_q | tclk_low;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      excess_zero_detect_out <= 8'h00;
      violation_detect_out   <= 8'h00;
    end else begin
      excess_zero_detect_out <= excess_zero_detect_enable_q & hdb3_single;
      violation_detect_out   <= ~violation_detect_disable_q & hdb3_single;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_expanded_out <= 1'b0;
    end else begin
      bank_expanded_out <= expanded;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_reset_active_out <= 1'b0;
    end else begin
      sw_reset_active_out <= in_reset;
    end
  end
endmodule : e1rb_bank_ctrl

// >>> testbench/e1rb_bank_ctrl_checker.sv
`timescale 1ns/1ps
module e1rb_bank_ctrl_checker (
  // clock and reset
  input wire logic       mclk_in,
  input wire logic       rstn_in,
  // host and line pins
  input wire logic       host_cs_n_in,
  input wire logic [7:0] transmit_clock_pin_in,
  // observed outputs
  input wire logic       host_data_oe_out,
  input wire logic       bank_expanded_out,
  input wire logic       sw_reset_active_out,
  input wire logic [7:0] single_rail_out,
  input wire logic [7:0] ami_select_out,
  input wire logic [7:0] clock_recovery_off_out,
  input wire logic [7:0] rx_powerdown_out,
  input wire logic [7:0] tx_powerdown_out,
  input wire logic [7:0] tx_driver_hiz_out,
  input wire logic [7:0] excess_zero_detect_out,
  input wire logic [7:0] violation_detect_out,
  input wire logic [7:0] rx_equalizer_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  logic [7:0] swcnt_q;
  logic [9:0] tlow_q;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      swcnt_q <= 8'h00;
    end else begin
      swcnt_q <= sw_reset_active_out ? swcnt_q + 8'h01 : 8'h00;
    end
  end

  // raw pin count; the design filters first, so the bound carries margin
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tlow_q <= 10'h000;
    end else begin
      tlow_q <= transmit_clock_pin_in[0] ? 10'h000 : (tlow_q == 10'h3ff ? tlow_q : tlow_q + 10'h001);
    end
  end

  property p_rst_primary; $rose(rstn_in) |-> !bank_expanded_out && !host_data_oe_out; endproperty
  a_rst_primary: assert property (p_rst_primary) else $error("bank not primary after reset");
  property p_bank_idle; host_cs_n_in [*8] |-> $stable(bank_expanded_out); endproperty
  a_bank_idle: assert property (p_bank_idle) else $error("bank changed without access");
  property p_cs_idle; host_cs_n_in [*8] |-> !host_data_oe_out; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("data bus driven while deselected");
  property p_hiz; tx_driver_hiz_out == tx_powerdown_out; endproperty
  a_hiz: assert property (p_hiz) else $error("driver high-z differs from powerdown");
  property p_ami; (ami_select_out & ~single_rail_out) == 8'h00; endproperty
  a_ami: assert property (p_ami) else $error("ami without single rail");
  property p_exz; (excess_zero_detect_out & (ami_select_out | ~single_rail_out)) == 8'h00; endproperty
  a_exz: assert property (p_exz) else $error("excess zero detect outside hdb3 single rail");
  property p_viol; (violation_detect_out & (ami_select_out | ~single_rail_out)) == 8'h00; endproperty
  a_viol: assert property (p_viol) else $error("violation detect outside hdb3 single rail");
  property p_tclk; tlow_q >= 10'd520 |-> tx_powerdown_out[0]; endproperty
  a_tclk: assert property (p_tclk) else $error("low transmit clock not powering down");
  property p_sw_len; $fell(sw_reset_active_out) |-> swcnt_q == 8'd125; endproperty
  a_sw_len: assert property (p_sw_len) else $error("soft reset length wrong");
  property p_sw_dflt;
    sw_reset_active_out && $past(sw_reset_active_out, 2) |->
      !bank_expanded_out && (clock_recovery_off_out | rx_powerdown_out | rx_equalizer_out) == 8'h00;
  endproperty
  a_sw_dflt: assert property (p_sw_dflt) else $error("registers not default in soft reset");
endmodule : e1rb_bank_ctrl_checker

bind e1rb_bank_ctrl e1rb_bank_ctrl_checker i_e1rb_bank_ctrl_checker (
  .mclk_in, .rstn_in, .host_cs_n_in, .transmit_clock_pin_in, .host_data_oe_out, .bank_expanded_out,
  .sw_reset_active_out, .single_rail_out, .ami_select_out, .clock_recovery_off_out, .rx_powerdown_out,
  .tx_powerdown_out, .tx_driver_hiz_out, .excess_zero_detect_out, .violation_detect_out, .rx_equalizer_out
);

// >>> testbench/e1rb_bank_ctrl_tb.sv
`timescale 1ns/1ps
`include "e1rb_defs.svh"
module e1rb_bank_ctrl_tb import e1rb_pkg::*;;
  logic mclk_in, rstn_in, host_cs_n_in, host_wr_n_in, host_rd_n_in, host_data_oe_out;
  logic [4:0] host_addr_in;
  logic [7:0] host_data_in, host_data_out, transmit_negative_data_pin_in, transmit_clock_pin_in;
  logic bank_expanded_out, sw_reset_active_out;
  logic [7:0] single_rail_out, ami_select_out, clock_recovery_off_out, rx_powerdown_out;
  logic [7:0] tx_powerdown_out, tx_driver_hiz_out, excess_zero_detect_out, violation_detect_out;
  logic [7:0] rx_equalizer_out;
  int fails = 0;
  int tests_run = 0;
  e1rb_byte_t got;
  // crs row first, so the derived modes settle with their final inputs
  logic [4:0] row_a [8] = '{5'h02, 5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
  e1rb_byte_t row_d [8] = '{8'hc0, 8'h55, 8'h0f, 8'ha5, 8'h3c, 8'hf0, 8'h96, 8'h81};
  e1rb_byte_t row_e [8] = '{8'hc0, 8'h55, 8'h0f, 8'ha5, 8'h3c, 8'hf0, 8'h96, 8'h81};

  e1rb_bank_ctrl i_e1rb_bank_ctrl (
    .mclk_in, .rstn_in, .host_cs_n_in, .host_wr_n_in, .host_rd_n_in, .host_addr_in, .host_data_in,
    .host_data_out, .host_data_oe_out, .transmit_negative_data_pin_in, .transmit_clock_pin_in,
    .bank_expanded_out, .sw_reset_active_out, .single_rail_out, .ami_select_out, .clock_recovery_off_out,
    .rx_powerdown_out, .tx_powerdown_out, .tx_driver_hiz_out, .excess_zero_detect_out,
    .violation_detect_out, .rx_equalizer_out
  );

  task automatic close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    tests_run++;
    if (got_v !== exp_v) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  // write strobe held 8 cycles, chip select 16: the pin filter needs 4
  task automatic wr(input logic [4:0] a, input e1rb_byte_t d);
    @(posedge mclk_in);
    host_addr_in <= a;
    host_data_in <= d;
    host_cs_n_in <= 1'b0;
    host_wr_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    host_wr_n_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    host_cs_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, output e1rb_byte_t d);
    @(posedge mclk_in);
    host_addr_in <= a;
    host_cs_n_in <= 1'b0;
    host_rd_n_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    #1;
    d = host_data_out;
    chk({7'h00, host_data_oe_out}, 8'h01);
    @(posedge mclk_in);
    host_cs_n_in <= 1'b1;
    host_rd_n_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
  endtask : rd

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    close_out();
  end

  initial begin
    rstn_in = 1'b0;
    host_cs_n_in = 1'b1;
    host_wr_n_in = 1'b1;
    host_rd_n_in = 1'b1;
    host_addr_in = 5'h00;
    host_data_in = 8'h00;
    transmit_negative_data_pin_in = 8'h33;
    transmit_clock_pin_in = 8'hff;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    chk({7'h00, bank_expanded_out}, 8'h00);
    chk(clock_recovery_off_out | rx_powerdown_out | tx_powerdown_out | rx_equalizer_out, 8'h00);
    rd(5'h00, got);
    chk(got, 8'h00);
    wr(`E1RB_OFF_BANK, 8'h55);
    chk({7'h00, bank_expanded_out}, 8'h00);
    wr(`E1RB_OFF_BANK, `E1RB_BANK_EXPANDED);
    chk({7'h00, bank_expanded_out}, 8'h01);
    rd(`E1RB_OFF_BANK, got);
    chk(got, `E1RB_BANK_EXPANDED);
    for (int i = 0; i < 8; i++) begin
      wr(row_a[i], row_d[i]);
      rd(row_a[i], got);
      chk(got, row_e[i]);
    end
    rd(5'h08, got);
    chk(got, 8'h00);
    chk(clock_recovery_off_out, 8'hc0);
    chk(rx_powerdown_out, 8'ha5);
    chk(tx_powerdown_out, 8'h3c);
    chk(tx_driver_hiz_out, 8'h3c);
    chk(rx_equalizer_out, 8'h81);
    chk(ami_select_out, 8'h05);
    // channels with recovery off have no defined rail mode, so they are masked
    chk(single_rail_out & 8'h3f, 8'h37);
    chk(excess_zero_detect_out & 8'h3f, 8'h30);
    chk(violation_detect_out & 8'h3f, 8'h20);
    @(posedge mclk_in);
    transmit_negative_data_pin_in <= 8'h00;
    repeat (8) @(posedge mclk_in);
    #1;
    chk(single_rail_out & 8'h3f, 8'h15);
    @(posedge mclk_in);
    transmit_clock_pin_in <= 8'hfe;
    repeat (520) @(posedge mclk_in);
    #1;
    chk(tx_powerdown_out, 8'h3d);
    @(posedge mclk_in);
    transmit_clock_pin_in <= 8'hff;
    repeat (10) @(posedge mclk_in);
    #1;
    chk(tx_powerdown_out, 8'h3c);
    wr(`E1RB_OFF_BANK, `E1RB_BANK_PRIMARY);
    chk({7'h00, bank_expanded_out}, 8'h00);
    rd(`E1RB_OFF_RXPD, got);
    chk(got, 8'h00);
    wr(`E1RB_OFF_SWRST, 8'h12);
    chk({7'h00, sw_reset_active_out}, 8'h01);
    wr(`E1RB_OFF_BANK, `E1RB_BANK_EXPANDED);
    for (int n = 0; n < 200 && sw_reset_active_out !== 1'b0; n++) @(posedge mclk_in);
    #1;
    // a reset cycle that never ends would otherwise leave every default in place and pass
    chk({7'h00, sw_reset_active_out}, 8'h00);
    chk({7'h00, bank_expanded_out}, 8'h00);
    chk(clock_recovery_off_out | rx_powerdown_out | tx_powerdown_out | rx_equalizer_out, 8'h00);
    rd(`E1RB_OFF_SWRST, got);
    chk(got, `E1RB_SWRST_RDVAL);
    // pin reset in mid-run must clear the bank and the registers at once
    wr(`E1RB_OFF_BANK, `E1RB_BANK_EXPANDED);
    wr(`E1RB_OFF_RXPD, 8'h5a);
    chk(rx_powerdown_out, 8'h5a);
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk(rx_powerdown_out | {7'h00, bank_expanded_out}, 8'h00);
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    rd(`E1RB_OFF_BANK, got);
    chk(got, `E1RB_BANK_PRIMARY);
    close_out();
  end
endmodule : e1rb_bank_ctrl_tb
